// *** verif/t1c_ext_src.sv ***
// Model of the external clock source driving the timer's clock pins.
// Assumes go_i is a one-cycle pulse from the bench on ref_clk_i.
`timescale 1ns/10ps
module t1c_ext_src #(
	parameter int HALF  = 4,
	parameter int EDGES = 10
) (
	// Clock and control.
	input  wire logic ref_clk_i,
	input  wire logic go_i,
	input  wire logic use_osc_i,
	// Pins and burst flag.
	output logic      ext_clock_pin_o,
	output logic      osc_input_pin_o,
	output logic      busy_o
);
	int   cnt = 0;
	logic run_reg = 1'b0;
	logic lvl;

	// Runs one burst of edges, then stands still low.
	always @(posedge ref_clk_i) begin
		if (run_reg) begin
			cnt <= cnt + 1;
		end else begin
			cnt <= 0;
		end
		if (go_i) begin
			run_reg <= 1'b1;
		end else if (cnt == 2 * HALF * EDGES - 1) begin
			run_reg <= 1'b0;
		end
	end

	// The burst flag has a single driver, the process above.
	assign busy_o = run_reg;

	// High and low each last HALF clocks, so the period is 2*HALF.
	assign lvl = run_reg && (cnt % (2 * HALF) >= HALF);
	assign ext_clock_pin_o = lvl && !use_osc_i;
	assign osc_input_pin_o = lvl && use_osc_i;
endmodule : t1c_ext_src

// *** verif/tb_top.sv ***
// Self-checking bench for the timer core over APB.
// Assumes a one-cycle APB answer and the clock source model.
`timescale 1ns/10ps
module tb_top import t1c_pkg::*;;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        perr;
	logic        pin;
	logic        osc;
	logic        sleep = 1'b0;
	logic        cc1 = 1'b1; // Clears the count pair while reset is held.
	logic        cc2 = 1'b0;
	logic        irq;
	logic        go = 1'b0;
	logic        uosc = 1'b0;
	logic        busy;
	logic [1:0]  dir = 2'b00;
	logic [1:0]  dir_eff;
	int          mismatches = 0;
	int          cmp_count = 0;
	logic [7:0]  ctl_t [7] = '{8'h03, 8'h0b, 8'h0b, 8'h07, 8'h03, 8'h07, 8'h02};
	logic [6:0]  osc_m = 7'b0000010;
	logic [6:0]  slp_m = 7'b0110000;
	logic [6:0]  cnt_m = 7'b0101011;

	// Clock of 25 MHz.
	always #20 ref_clk_i = ~ref_clk_i;

	t1c_timer_core t1c_timer_core_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ext_clock_pin_i(pin),
		.osc_input_pin_i(osc), .port_c_direction_i(dir),
		.port_c_dir_eff_o(dir_eff), .sleep_i(sleep),
		.capcomp_unit_one_i(cc1), .capcomp_unit_two_i(cc2), .irq_o(irq));

	t1c_ext_src t1c_ext_src_inst (
		.ref_clk_i(ref_clk_i), .go_i(go), .use_osc_i(uosc),
		.ext_clock_pin_o(pin), .osc_input_pin_o(osc), .busy_o(busy));

	task automatic report_and_stop;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk_i);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			report_and_stop;
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wcnt(input logic [15:0] v);
		apb(1'b1, OFF_COUNT_LOW, {24'h0, v[7:0]});
		apb(1'b1, OFF_COUNT_HIGH, {24'h0, v[15:8]});
	endtask : wcnt

	task automatic rcnt(output logic [15:0] c);
		apb(1'b0, OFF_COUNT_LOW, 32'h0);
		c[7:0] = rdat[7:0];
		apb(1'b0, OFF_COUNT_HIGH, 32'h0);
		c[15:8] = rdat[7:0];
	endtask : rcnt

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : idle

	// Main sequence.
	initial begin
		logic [15:0] c;
		int          e;
		idle(5);
		rst_i <= 1'b0;
		cc1 <= 1'b0;
		apb(1'b0, OFF_CONTROL, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, perr}, 32'h1);
		apb(1'b1, OFF_CONTROL, 32'hff);
		apb(1'b0, OFF_CONTROL, 32'h0);
		chk(rdat, 32'h3f);
		for (int p = 0; p < 4; p++) begin
			wcnt(16'h0);
			apb(1'b1, OFF_CONTROL, {26'h0, p[1:0], 4'h5});
			idle(253);
			apb(1'b1, OFF_CONTROL, 32'h0);
			rcnt(c);
			e = 64 >> p;
			chk({31'h0, c >= e - 2 && c <= e + 2}, 32'h1);
		end
		wcnt(16'h00a5);
		idle(40);
		rcnt(c);
		chk({16'h0, c}, 32'ha5);
		wcnt(16'hfffe);
		apb(1'b1, OFF_ENABLE, 32'h1);
		apb(1'b1, OFF_CONTROL, 32'h1);
		idle(20);
		apb(1'b1, OFF_CONTROL, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk({31'h0, rdat[0]}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rcnt(c);
		chk({31'h0, c < 16'h10}, 32'h1);
		apb(1'b1, OFF_ENABLE, 32'h0);
		idle(3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk({31'h0, rdat[0]}, 32'h1);
		apb(1'b1, OFF_FLAG, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk({31'h0, rdat[0]}, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wcnt(16'h1234);
			{cc2, cc1} <= i[0] ? 2'b10 : 2'b01;
			idle(1);
			{cc2, cc1} <= 2'b00;
			rcnt(c);
			chk({16'h0, c}, 32'h0);
		end
		cc1 <= 1'b1;
		apb(1'b1, OFF_COUNT_LOW, 32'h77);
		cc1 <= 1'b0;
		apb(1'b0, OFF_COUNT_LOW, 32'h0);
		chk({24'h0, rdat[7:0]}, 32'h77);
		// Pin source, sync mode and sleep combinations.
		for (int i = 0; i < 7; i++) begin
			wcnt(16'h0);
			dir <= i[1:0];
			sleep <= slp_m[i];
			uosc <= osc_m[i];
			apb(1'b1, OFF_CONTROL, {24'h0, ctl_t[i]});
			idle(2);
			chk({30'h0, dir_eff}, ctl_t[i][3] ? 32'h3 : i[1:0]);
			go <= 1'b1;
			idle(1);
			go <= 1'b0;
			idle(1);
			for (e = 0; e < 200 && busy !== 1'b0; e++) idle(1);
			if (e == 200) begin
				mismatches++;
				report_and_stop;
			end
			idle(12);
			sleep <= 1'b0;
			apb(1'b1, OFF_CONTROL, 32'h0);
			rcnt(c);
			chk({16'h0, c}, cnt_m[i] ? 32'ha : 32'h0);
		end
		wcnt(16'h5aa5);
		apb(1'b1, OFF_CONTROL, 32'h30);
		rst_i <= 1'b1;
		idle(1);
		rst_i <= 1'b0;
		apb(1'b0, OFF_CONTROL, 32'h0);
		chk(rdat, 32'h0);
		rcnt(c);
		chk({16'h0, c}, 32'h5aa5);
		report_and_stop;
	end
endmodule : tb_top

// *** verilog/t1c_pkg.sv ***
// Constants shared by the 16-bit timer/counter core.
// Assumes an APB master with 32-bit data and byte addresses.
package t1c_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFF_COUNT_LOW  = 8'h00;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
	localparam logic [7:0] OFF_FLAG       = 8'h08;
	localparam logic [7:0] OFF_ENABLE     = 8'h0c;
	localparam logic [7:0] OFF_CONTROL    = 8'h10;

	// Field positions in the control and flag registers.
	localparam int CTL_TIMER_ON = 0;
	localparam int CTL_CLK_SEL  = 1;
	localparam int CTL_SYNC_DIS = 2;
	localparam int CTL_OSC_EN   = 3;
	localparam int CTL_PS_LO    = 4;
	localparam int CTL_PS_HI    = 5;
	localparam int FLAG_BIT     = 0;

	// Values after power-on reset, and the count limits.
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic       FLAG_RESET    = 1'h0;
	localparam logic       ENABLE_RESET  = 1'h0;
	localparam logic [2:0] PSC_RESET     = 3'h0;
	localparam logic [15:0] COUNT_MAX    = 16'hffff;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;

	// Four oscillator periods make one instruction cycle.
	typedef enum logic [1:0] {
		T1C_PH_ONE   = 2'b00,
		T1C_PH_TWO   = 2'b01,
		T1C_PH_THREE = 2'b10,
		T1C_PH_FOUR  = 2'b11
	} t1c_phase_t;
endpackage : t1c_pkg

// *** verilog/t1c_timer_core.sv ***
// 16-bit timer/counter core with an APB register slave.
// Assumes ref_clk_i is the oscillator and the event inputs share its clock.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
// Behaviour
// - Sixteen-bit count in two writable bytes, counts up and wraps to zero.
// - Wrap of the count sets the overflow flag, bit 0 of flag register.
// - Interrupt output raised only while overflow enable bit 0 is set.
// - With clock select clear, count once per four oscillator periods.
// - Sync disable bit has no effect in internal clock mode.
// - Clock select set counts oscillator pin if enabled, else clock pin.
// - Counter runs only while the timer-on bit is set.
// - Either compare unit event clears the count.
// - Oscillator enable forces both port pins to inputs; legacy forces one.
// - Prescale field 11, 10, 01, 00 divides by 8, 4, 2, 1.
// - Sync disable clear synchronises external input; set does not.
// - Synchronisation sits after the prescaler driven by external edges.
// - Synchronised counting stops in sleep while the prescaler keeps going.
// - Prescaler output is sampled on phases two and four.
// - Synchronised increment lags the external edge.
// - Two upper control bits read as zero.
// - Implemented control bits are read/write and reset to zero.
// - Unsynchronised counting continues in sleep and can flag overflow.
// - Software count write wins over a compare reset.
// - Reset clears control, flag and enable; the count is never reset.
module t1c_timer_core
	import t1c_pkg::*;
#(
	parameter bit LEGACY_ONE_PIN = 1'b0
) (
	// Clock and power-on reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// External clock pins.
	input  wire logic        ext_clock_pin_i,
	input  wire logic        osc_input_pin_i,
	// Port direction handling.
	input  wire logic [1:0]  port_c_direction_i,
	output logic      [1:0]  port_c_dir_eff_o,
	// System events.
	input  wire logic        sleep_i,
	input  wire logic        capcomp_unit_one_i,
	input  wire logic        capcomp_unit_two_i,
	output logic             irq_o
);

	t1c_phase_t  phase_reg;
	logic [5:0]  control_reg;
	logic [15:0] count_reg;
	logic        flag_reg;
	logic        enable_reg;
	logic [2:0]  sync_reg;
	logic        stable_reg;
	logic [2:0]  psc_reg;
	logic        psc_prev_reg;
	logic        samp_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;
	logic [1:0]  dir_reg;
	logic        irq_reg;

	logic        timer_on;
	logic        clk_sel;
	logic        sync_dis;
	logic        osc_en;
	logic [1:0]  ps_sel;
	logic        ext_raw;
	logic        ext_rise;
	logic        psc_level;
	logic [2:0]  psc_mask;
	logic        int_tick;
	logic        int_inc;
	logic        sample_pt;
	logic        sync_rise;
	logic        async_rise;
	logic        cnt_inc;
	logic        special;
	logic        wr_en;
	logic        wr_low;
	logic        wr_high;
	logic        wr_count;
	logic        overflow_evt;
	logic        mapped;
	logic [31:0] rd_mux;

	assign timer_on = control_reg[CTL_TIMER_ON];
	assign clk_sel  = control_reg[CTL_CLK_SEL];
	assign sync_dis = control_reg[CTL_SYNC_DIS];
	assign osc_en   = control_reg[CTL_OSC_EN];
	assign ps_sel   = control_reg[CTL_PS_HI:CTL_PS_LO];

	// Quarter-rate phase sequencer for the instruction cycle.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= T1C_PH_ONE;
		end else begin
			case (phase_reg)
				T1C_PH_ONE:   phase_reg <= T1C_PH_TWO;
				T1C_PH_TWO:   phase_reg <= T1C_PH_THREE;
				T1C_PH_THREE: phase_reg <= T1C_PH_FOUR;
				T1C_PH_FOUR:  phase_reg <= T1C_PH_ONE;
				default:      phase_reg <= T1C_PH_ONE;
			endcase
		end
	end

	// Select the external source before the pin synchroniser.
	assign ext_raw = osc_en ? osc_input_pin_i : ext_clock_pin_i;

	// Three-stage pin synchroniser; stage two and three must agree.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg   <= 3'h0;
			stable_reg <= 1'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], ext_raw};
			if (sync_reg[1] == sync_reg[2]) begin
				stable_reg <= sync_reg[2];
			end
		end
	end

	assign ext_rise = ~stable_reg & sync_reg[1] & sync_reg[2];
	assign int_tick = (phase_reg == T1C_PH_FOUR) & ~sleep_i;

	// Prescaler is driven straight by source edges; external edges also in sleep.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			psc_reg <= PSC_RESET;
		end else if (clk_sel ? ext_rise : int_tick) begin
			psc_reg <= psc_reg + 3'h1;
		end
	end

	// Prescaler output level and full-count mask per ratio.
	always_comb begin
		psc_level = stable_reg;
		psc_mask  = 3'h0;
		case (ps_sel)
			2'h0: begin
				psc_level = stable_reg;
				psc_mask  = 3'h0;
			end
			2'h1: begin
				psc_level = psc_reg[0];
				psc_mask  = 3'h1;
			end
			2'h2: begin
				psc_level = psc_reg[1];
				psc_mask  = 3'h3;
			end
			2'h3: begin
				psc_level = psc_reg[2];
				psc_mask  = 3'h7;
			end
			default: begin
				psc_level = stable_reg;
				psc_mask  = 3'h0;
			end
		endcase
	end

	// Internal mode never consults the sync disable bit.
	assign int_inc = int_tick & ((psc_reg & psc_mask) == psc_mask);

	// Sampling on phases two and four; the sampler halts in sleep.
	assign sample_pt = ((phase_reg == T1C_PH_TWO) |
		(phase_reg == T1C_PH_FOUR)) & ~sleep_i;
	assign sync_rise  = sample_pt & psc_level & ~samp_reg;
	assign async_rise = psc_level & ~psc_prev_reg;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			samp_reg     <= 1'h0;
			psc_prev_reg <= 1'h0;
		end else begin
			psc_prev_reg <= psc_level;
			if (sample_pt) begin
				samp_reg <= psc_level;
			end
		end
	end

	// Increment decision for the count pair.
	assign cnt_inc = timer_on & (clk_sel ?
		(sync_dis ? async_rise : sync_rise) : int_inc);
	assign special = capcomp_unit_one_i | capcomp_unit_two_i;

	// APB write strobes in the access phase.
	assign wr_en    = psel_i & penable_i & pwrite_i & pready_reg;
	assign wr_low   = wr_en & (paddr_i == OFF_COUNT_LOW);
	assign wr_high  = wr_en & (paddr_i == OFF_COUNT_HIGH);
	assign wr_count = wr_low | wr_high;

	// Count pair has no power-on reset; while rst_i is high only a compare event can change it.
	always_ff @(posedge ref_clk_i) begin
		if (wr_count) begin
			if (wr_low) begin
				count_reg[7:0] <= pwdata_i[7:0];
			end
			if (wr_high) begin
				count_reg[15:8] <= pwdata_i[7:0];
			end
		end else if (special) begin
			count_reg <= COUNT_ZERO;
		end else if (cnt_inc) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	assign overflow_evt = cnt_inc & ~wr_count & ~special &
		(count_reg == COUNT_MAX);

	// Control, flag and enable registers; set wins over a clear.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			control_reg <= CONTROL_RESET;
			flag_reg    <= FLAG_RESET;
			enable_reg  <= ENABLE_RESET;
		end else begin
			if (wr_en & (paddr_i == OFF_CONTROL)) begin
				control_reg <= pwdata_i[5:0];
			end
			if (overflow_evt) begin
				flag_reg <= 1'h1;
			end else if (wr_en & (paddr_i == OFF_FLAG)) begin
				flag_reg <= pwdata_i[FLAG_BIT];
			end
			if (wr_en & (paddr_i == OFF_ENABLE)) begin
				enable_reg <= pwdata_i[FLAG_BIT];
			end
		end
	end

	// Masked interrupt and forced pin directions.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_reg <= 1'h0;
			dir_reg <= 2'h3;
		end else begin
			irq_reg <= flag_reg & enable_reg;
			if (osc_en) begin
				dir_reg <= LEGACY_ONE_PIN ?
					{1'h1, port_c_direction_i[0]} : 2'h3;
			end else begin
				dir_reg <= port_c_direction_i;
			end
		end
	end

	// Read multiplexer; upper control bits read as zero.
	always_comb begin
		mapped = 1'h1;
		rd_mux = 32'h0;
		case (paddr_i)
			OFF_COUNT_LOW:  rd_mux = {24'h0, count_reg[7:0]};
			OFF_COUNT_HIGH: rd_mux = {24'h0, count_reg[15:8]};
			OFF_FLAG:       rd_mux = {31'h0, flag_reg};
			OFF_ENABLE:     rd_mux = {31'h0, enable_reg};
			OFF_CONTROL:    rd_mux = {26'h0, control_reg};
			default:        mapped = 1'h0;
		endcase
	end

	// Zero-wait APB answer prepared in the setup cycle.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_reg  <= 1'h0;
			pslverr_reg <= 1'h0;
			prdata_reg  <= 32'h0;
		end else if (psel_i & ~penable_i) begin
			pready_reg  <= 1'h1;
			pslverr_reg <= ~mapped;
			prdata_reg  <= pwrite_i ? 32'h0 : rd_mux;
		end else begin
			pready_reg  <= 1'h0;
			pslverr_reg <= 1'h0;
		end
	end

	assign prdata_o         = prdata_reg;
	assign pready_o         = pready_reg;
	assign pslverr_o        = pslverr_reg;
	assign port_c_dir_eff_o = dir_reg;
	assign irq_o            = irq_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	chk_wrap_sets_flag: assert property (
		overflow_evt |=> flag_reg ##1 (irq_o == enable_reg || $past(
		wr_en))) else $error("Wrap did not set the overflow flag.");
	chk_irq_masked: assert property (
		(!enable_reg)[*2] |-> !irq_o
	) else $error("Interrupt raised while masked.");
	chk_internal_phase: assert property (
		cnt_inc && !clk_sel |-> phase_reg == T1C_PH_FOUR && !sleep_i
	) else $error("Internal increment off phase four.");
	chk_stop_when_off: assert property (
		!timer_on && !wr_count && !special |=> $stable(count_reg)
	) else $error("Count moved while timer is off.");
	chk_special_clears: assert property (
		special && !wr_count |=> count_reg == COUNT_ZERO
	) else $error("Compare event did not clear the count.");
	chk_write_wins: assert property (
		wr_low && special |=> count_reg[7:0] == $past(pwdata_i[7:0])
	) else $error("Compare reset beat a software write.");
	chk_sleep_sync_hold: assert property (
		sleep_i && clk_sel && !sync_dis && !wr_count && !special
		|=> $stable(count_reg)
	) else $error("Synchronised count moved during sleep.");
	chk_upper_zero: assert property (
		pready_o && !$past(pwrite_i) && $past(paddr_i) == OFF_CONTROL
		|-> prdata_o[31:6] == 26'h0
	) else $error("Upper control bits not zero.");
	chk_pins_forced: assert property (
		osc_en && !LEGACY_ONE_PIN |=> port_c_dir_eff_o == 2'h3
	) else $error("Oscillator pins not forced to inputs.");
	chk_flag_sticky: assert property (
		flag_reg && !(wr_en && paddr_i == OFF_FLAG) |=> flag_reg
	) else $error("Overflow flag dropped without a clear.");

	cov_overflow: cover property (overflow_evt);
	cov_special: cover property (special && timer_on);
	cov_sync_inc: cover property (cnt_inc && clk_sel && !sync_dis);
	cov_async_sleep: cover property (cnt_inc && sync_dis && sleep_i);

endmodule : t1c_timer_core
